// file: hdl/sooc_ctrl.sv
// supply on/off command control: operation decode, on/off configuration,
// write protection, fault clearing and alert
// assumes commands arrive on link_clk one at a time; pins are asynchronous
// Behaviour
// - op enabled: 00h hard off, 40h soft off, 80h on
// - decode 94h/98h low, A4h/A8h high margin codes
// - margining waits until all channels power good
// - op disabled: on/off ignored, margin still applied
// - margin only for enabled supply, pg or forced
// - bit4 clear: supplies follow bias, pin ignored
// - bit4 set: only pin and/or operation switch
// - bit3 enables and requires operation on/off
// - bit2 enables and requires control pin
// - bit1 picks pin polarity, 1 active high
// - bit0 picks pin off: 1 immediate, 0 soft
// - both enabled: both to turn on, either off
// - clear faults drops status bits and alert
// - clear never restarts supplies; requests only switch
// - persisting fault resets status, no new alert
// - clear faults only accepted without data byte
// - reads always allowed whatever the protection
// - invalid operation byte flags fault, raises alert
// - protection levels 80h/40h/20h/00h gate writes
`timescale 1ns/100ps
`include "sooc_consts.svh"
module sooc_ctrl (
  // core clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // command link
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic lk_cmd_valid,
  input wire sooc_pkg::sooc_cmd_s lk_cmd,
  output logic lk_busy,
  output logic lk_rvalid,
  output logic [7:0] lk_rdata,
  // pins
  input wire logic ctrl_pin,
  input wire logic bias_ok,
  input wire logic pg_forced,
  input wire logic [15:0] pgood_in,
  // monitor events, core clock
  input wire logic [15:0] fault_now,
  input wire logic wdog_event,
  // supply control
  output logic [15:0] supply_enable_outputs,
  output logic off_soft,
  output sooc_pkg::sooc_margin_e margin_sel,
  output logic margin_act_faults,
  output logic margin_active,
  output logic alert
);
  import sooc_pkg::*;

  function automatic logic op_valid(input logic [7:0] c);
    op_valid = (c == `SOOC_OP_OFF_NOW) || (c == `SOOC_OP_OFF_SOFT) || (c == `SOOC_OP_ON) ||
               (c == `SOOC_OP_LOW_IGN) || (c == `SOOC_OP_LOW_ACT) ||
               (c == `SOOC_OP_HIGH_IGN) || (c == `SOOC_OP_HIGH_ACT);
  endfunction

  function automatic sooc_margin_e op_margin(input logic [7:0] c);
    if (c == `SOOC_OP_LOW_IGN || c == `SOOC_OP_LOW_ACT)
      op_margin = SOOC_MARG_LOW;
    else if (c == `SOOC_OP_HIGH_IGN || c == `SOOC_OP_HIGH_ACT)
      op_margin = SOOC_MARG_HIGH;
    else
      op_margin = SOOC_MARG_OFF;
  endfunction

  function automatic logic wp_allows(input logic [7:0] wp, input logic [7:0] c);
    if (c == `SOOC_CMD_WRITE_PROT)
      wp_allows = 1'b1;
    else if (wp == `SOOC_WP_ALL)
      wp_allows = 1'b0;
    else if (wp == `SOOC_WP_OP)
      wp_allows = (c == `SOOC_CMD_OPERATION);
    else if (wp == `SOOC_WP_CFG)
      wp_allows = (c == `SOOC_CMD_OPERATION) || (c == `SOOC_CMD_ON_OFF_CFG);
    else
      wp_allows = 1'b1;
  endfunction

  // pins through two flops
  logic [18:0] pin_sync;
  sooc_sync2 #(.W(19)) u_pins (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({ctrl_pin, bias_ok, pg_forced, pgood_in}),
    .q(pin_sync)
  );
  wire pin_s = pin_sync[18];
  wire bias_s = pin_sync[17];
  wire pgf_s = pin_sync[16];
  wire [15:0] pg_s = pin_sync[15:0];

  // command in, read answer out
  logic cmd_stb;
  sooc_cmd_s cmd;
  logic rd_stb_r;
  logic [7:0] rd_data_r;
  sooc_xfer #(.W($bits(sooc_cmd_s))) u_cmd (
    .src_clk(link_clk),
    .src_rst_n(link_rst_n),
    .src_valid(lk_cmd_valid),
    .src_data(lk_cmd),
    .src_busy(lk_busy),
    .dst_clk(ref_clk),
    .dst_rst_n(rst_n),
    .dst_valid(cmd_stb),
    .dst_data(cmd)
  );
  // the host waits for lk_rvalid before its next read, so the return never backs up
  sooc_xfer #(.W(8)) u_rsp (
    .src_clk(ref_clk),
    .src_rst_n(rst_n),
    .src_valid(rd_stb_r),
    .src_data(rd_data_r),
    .src_busy(),
    .dst_clk(link_clk),
    .dst_rst_n(link_rst_n),
    .dst_valid(lk_rvalid),
    .dst_data(lk_rdata)
  );

  logic [7:0] op_r, cfg_r, wp_r;
  logic [15:0] fstat_r, fault_d_r, sup_r;
  logic cml_r, por_r, wdog_r, alert_r, bias_d_r, pin_d_r, off_soft_r;
  logic marg_act_r, marg_on_r;
  sooc_margin_e marg_r;

  // command decode
  wire is_wr = cmd_stb & ~cmd.is_read;
  wire is_rd = cmd_stb & cmd.is_read;
  wire hit_op = (cmd.code == `SOOC_CMD_OPERATION);
  wire hit_cfg = (cmd.code == `SOOC_CMD_ON_OFF_CFG);
  wire hit_clr = (cmd.code == `SOOC_CMD_CLEAR_FAULTS);
  wire hit_wp = (cmd.code == `SOOC_CMD_WRITE_PROT);
  wire hit_vs = (cmd.code == `SOOC_CMD_VENDOR_STAT);
  wire hit_flo = (cmd.code == `SOOC_CMD_FAULT_LO);
  wire hit_fhi = (cmd.code == `SOOC_CMD_FAULT_HI);
  wire hit_rw = hit_op | hit_cfg | hit_wp;
  wire wr_ok = wp_allows(wp_r, cmd.code);
  wire wp_good = (cmd.data == `SOOC_WP_ALL) || (cmd.data == `SOOC_WP_OP) ||
                 (cmd.data == `SOOC_WP_CFG) || (cmd.data == `SOOC_WP_NONE);
  // blocked writes vanish silently; only malformed ones raise the fault
  wire op_wr = is_wr & hit_op & cmd.has_data & wr_ok;
  wire op_take = op_wr & op_valid(cmd.data);
  wire op_bad = op_wr & ~op_valid(cmd.data);
  wire cfg_take = is_wr & hit_cfg & cmd.has_data & wr_ok;
  wire wp_take = is_wr & hit_wp & cmd.has_data & wp_good;
  wire wp_bad = is_wr & hit_wp & cmd.has_data & ~wp_good;
  wire clr_take = is_wr & hit_clr & ~cmd.has_data & wr_ok;
  wire clr_bad = is_wr & hit_clr & cmd.has_data & wr_ok;
  wire rd_ok = hit_rw | hit_vs | hit_flo | hit_fhi;
  wire wr_known = hit_rw | hit_clr;
  wire unsup = (is_rd & ~rd_ok) | (is_wr & ~wr_known);
  wire cml_evt = op_bad | wp_bad | clr_bad | unsup;

  // on/off path
  wire use_ctl = cfg_r[`SOOC_CFG_USE_CTL];
  wire op_en = cfg_r[`SOOC_CFG_OP_EN];
  wire pin_en = cfg_r[`SOOC_CFG_PIN_EN];
  wire pin_on = cfg_r[`SOOC_CFG_PIN_POL] ? pin_s : ~pin_s;
  // a request is a move of the pin itself; a polarity write alone switches nothing
  wire pin_chg = pin_en & (pin_s != pin_d_r);
  wire op_on = op_take ? cmd.data[`SOOC_OP_ON_BIT] : op_r[`SOOC_OP_ON_BIT];
  // each enabled source must agree to be on, so any one of them can turn off
  wire want_on = (op_en | pin_en) & (~op_en | op_on) & (~pin_en | pin_on);
  wire op_evt = op_take & op_en;
  wire ctl_evt = use_ctl & (op_evt | pin_chg);
  wire auto_evt = ~use_ctl & (bias_s != bias_d_r);
  wire tgt_on = use_ctl ? want_on : bias_s;
  wire sup_evt = ctl_evt | auto_evt;
  wire off_now = op_evt ? (cmd.data == `SOOC_OP_OFF_NOW) : cfg_r[`SOOC_CFG_PIN_OFF_NOW];
  // enables move only on a request; clearing faults never touches them
  wire [15:0] sup_nxt = sup_evt ? {16{tgt_on}} : sup_r;
  wire off_soft_nxt = sup_evt ? (~tgt_on & ~(auto_evt | off_now)) : off_soft_r;

  // margin path, applied whatever the on/off enable
  wire marg_on_nxt = op_take ? (op_margin(cmd.data) != SOOC_MARG_OFF) : marg_on_r;
  wire pg_ready = (&pg_s) | pgf_s;
  wire marg_act_nxt = marg_on_r & (|sup_r) & pg_ready;

  // status; a new event in the clearing cycle wins over the clear
  wire [15:0] fault_rise = fault_now & ~fault_d_r;
  wire [15:0] fstat_nxt = (clr_take ? 16'h0000 : fstat_r) | fault_now;
  wire new_evt = (|fault_rise) | cml_evt | wdog_event;
  wire alert_nxt = (alert_r & ~clr_take) | new_evt;
  wire [7:0] vstat = {5'h00, cml_r, wdog_r, por_r};

  // reads answer regardless of protection level
  wire [7:0] rd_mux = hit_op ? op_r :
                      hit_cfg ? (cfg_r & `SOOC_CFG_MASK) :
                      hit_wp ? wp_r :
                      hit_vs ? vstat :
                      hit_flo ? fstat_r[7:0] :
                      hit_fhi ? fstat_r[15:8] : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= `SOOC_OP_RST;
      cfg_r <= `SOOC_CFG_RST;
      wp_r <= `SOOC_WP_RST;
      marg_r <= SOOC_MARG_OFF;
      marg_act_r <= 1'b0;
      marg_on_r <= 1'b0;
    end else begin
      op_r <= op_take ? cmd.data : op_r;
      cfg_r <= cfg_take ? (cmd.data & `SOOC_CFG_MASK) : cfg_r;
      wp_r <= wp_take ? cmd.data : wp_r;
      marg_r <= op_take ? op_margin(cmd.data) : marg_r;
      marg_act_r <= op_take ? (cmd.data[3] & ~cmd.data[2]) : marg_act_r;
      marg_on_r <= marg_on_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_r <= 16'h0000;
      off_soft_r <= 1'b0;
      bias_d_r <= 1'b0;
      pin_d_r <= 1'b0;
      margin_active <= 1'b0;
    end else begin
      sup_r <= sup_nxt;
      off_soft_r <= off_soft_nxt;
      bias_d_r <= bias_s;
      pin_d_r <= pin_s;
      margin_active <= marg_act_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fstat_r <= 16'h0000;
      fault_d_r <= 16'h0000;
      cml_r <= 1'b0;
      por_r <= 1'b1;
      wdog_r <= 1'b0;
      alert_r <= 1'b0;
      rd_stb_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      fstat_r <= fstat_nxt;
      fault_d_r <= fault_now;
      cml_r <= (cml_r & ~clr_take) | cml_evt;
      por_r <= por_r & ~clr_take;
      wdog_r <= (wdog_r & ~clr_take) | wdog_event;
      alert_r <= alert_nxt;
      rd_stb_r <= is_rd;
      rd_data_r <= is_rd ? rd_mux : rd_data_r;
    end
  end

  assign supply_enable_outputs = sup_r;
  assign off_soft = off_soft_r;
  assign margin_sel = marg_r;
  assign margin_act_faults = marg_act_r;
  assign alert = alert_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_op_on_off: assert property (op_take && op_en && !pin_en && use_ctl && !pin_chg |=>
    supply_enable_outputs == ($past(cmd.data[7]) ? 16'hFFFF : 16'h0000))
    else $error("operation on/off not applied");
  chk_margin_decode: assert property (op_take && cmd.data == 8'h98 |=>
    margin_sel == SOOC_MARG_LOW && margin_act_faults)
    else $error("margin low decode wrong");
  chk_margin_gate: assert property ($rose(margin_active) |->
    $past(pg_ready) && $past(|sup_r))
    else $error("margining started before power good");
  chk_op_ignored: assert property (op_take && !op_en && !pin_chg && !auto_evt |=>
    $stable(supply_enable_outputs))
    else $error("disabled operation switched supplies");
  chk_bias_on: assert property (!use_ctl && bias_s && !bias_d_r |=>
    supply_enable_outputs == 16'hFFFF)
    else $error("supplies not on with bias");
  chk_pin_polarity: assert property (pin_chg && use_ctl && !op_en |=>
    supply_enable_outputs == ($past(pin_on) ? 16'hFFFF : 16'h0000))
    else $error("pin request misapplied");
  chk_pin_offtype: assert property (pin_chg && use_ctl && !op_take && !pin_on |=>
    off_soft == !$past(cfg_r[0]))
    else $error("pin turn-off action wrong");
  chk_either_off: assert property (ctl_evt && op_en && pin_en && !pin_on |=>
    supply_enable_outputs == 16'h0000)
    else $error("pin could not turn supplies off");
  chk_clear_alert: assert property (clr_take && !new_evt |=>
    !alert && !por_r && !cml_r && !wdog_r)
    else $error("clear faults left status or alert");
  chk_enable_cause: assert property (!$stable(supply_enable_outputs) |->
    $past(sup_evt))
    else $error("supply enables moved without request");
  chk_fault_persist: assert property (clr_take && !new_evt |=>
    fstat_r == $past(fault_now) && !alert)
    else $error("persisting fault handled wrong");
  chk_bad_op: assert property (op_bad |=> alert && cml_r)
    else $error("invalid operation byte not flagged");
  chk_wp_block: assert property (is_wr && hit_cfg && wp_r == 8'h40 |=>
    $stable(cfg_r))
    else $error("protected write landed");
  chk_read_free: assert property (is_rd && hit_cfg |=>
    rd_stb_r && rd_data_r == $past(cfg_r) && rd_data_r[7:5] == 3'h0)
    else $error("read blocked or wrong");

  cov_op_on: cover property (op_evt && cmd.data == 8'h80 ##1 supply_enable_outputs == 16'hFFFF);
  cov_margin_go: cover property ($rose(margin_active));
  cov_clear: cover property (alert ##1 clr_take ##1 !alert);
  cov_pin_off: cover property (pin_chg && !pin_on ##1 supply_enable_outputs == 16'h0000);
endmodule

// file: hdl/sooc_consts.svh
// supply on/off command control: command codes, field positions, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef SOOC_CONSTS_SVH
`define SOOC_CONSTS_SVH

// command codes on the link
`define SOOC_CMD_OPERATION 8'h01
`define SOOC_CMD_ON_OFF_CFG 8'h02
`define SOOC_CMD_CLEAR_FAULTS 8'h03
`define SOOC_CMD_WRITE_PROT 8'h10
`define SOOC_CMD_VENDOR_STAT 8'h80
`define SOOC_CMD_FAULT_LO 8'h81
`define SOOC_CMD_FAULT_HI 8'h82

// operation codes
`define SOOC_OP_OFF_NOW 8'h00
`define SOOC_OP_OFF_SOFT 8'h40
`define SOOC_OP_ON 8'h80
`define SOOC_OP_LOW_IGN 8'h94
`define SOOC_OP_LOW_ACT 8'h98
`define SOOC_OP_HIGH_IGN 8'hA4
`define SOOC_OP_HIGH_ACT 8'hA8
`define SOOC_OP_ON_BIT 7

// on/off configuration fields
`define SOOC_CFG_USE_CTL 4
`define SOOC_CFG_OP_EN 3
`define SOOC_CFG_PIN_EN 2
`define SOOC_CFG_PIN_POL 1
`define SOOC_CFG_PIN_OFF_NOW 0
`define SOOC_CFG_MASK 8'h1F

// write protection levels
`define SOOC_WP_ALL 8'h80
`define SOOC_WP_OP 8'h40
`define SOOC_WP_CFG 8'h20
`define SOOC_WP_NONE 8'h00

// vendor status fields
`define SOOC_VS_POR 0
`define SOOC_VS_WDOG 1
`define SOOC_VS_CML 2

// reset values
`define SOOC_CFG_RST 8'h00
`define SOOC_WP_RST 8'h00
`define SOOC_OP_RST 8'h00

`endif

// file: hdl/sooc_pkg.sv
// supply on/off command control: shared types
// assumes sooc_consts.svh on the include path
package sooc_pkg;
  `include "sooc_consts.svh"

  // one command as it arrives from the link
  typedef struct packed {
    logic is_read;
    logic has_data;
    logic [7:0] code;
    logic [7:0] data;
  } sooc_cmd_s;

  typedef enum logic [1:0] {
    SOOC_MARG_OFF,
    SOOC_MARG_LOW,
    SOOC_MARG_HIGH
  } sooc_margin_e;
endpackage

// file: hdl/sooc_sync2.sv
// two flip-flop level synchroniser for pins entering the core clock
// assumes each bit is an independent level; no bus coherence implied
`timescale 1ns/100ps
module sooc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// file: hdl/sooc_xfer.sv
// toggle handshake carrying one word from a source clock to a destination clock
// assumes the source honours src_busy; a word offered while busy is dropped
`timescale 1ns/100ps
module sooc_xfer #(
  parameter int W = 8
) (
  // source side
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_valid,
  input wire logic [W-1:0] src_data,
  output logic src_busy,
  // destination side
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);
  logic req_r, ack_m_r, ack_s_r;
  logic [W-1:0] hold_r;
  logic req_m_r, req_s_r, req_d_r;

  wire take = src_valid & ~src_busy;
  wire arrive = req_s_r ^ req_d_r;
  assign src_busy = req_r ^ ack_s_r;

  // hold_r stays still until the ack returns, so the far side may sample it
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      req_r <= 1'b0;
      hold_r <= '0;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      req_r <= req_r ^ take;
      hold_r <= take ? src_data : hold_r;
      ack_m_r <= req_d_r;
      ack_s_r <= ack_m_r;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      req_d_r <= 1'b0;
      dst_valid <= 1'b0;
      dst_data <= '0;
    end else begin
      req_m_r <= req_r;
      req_s_r <= req_m_r;
      req_d_r <= req_s_r;
      dst_valid <= arrive;
      dst_data <= arrive ? hold_r : dst_data;
    end
  end
endmodule

// file: dv/sooc_host.sv
// host side model: offers link commands and captures read answers
// assumes link_clk comes from the bench; one command at a time
`timescale 1ns/100ps
module sooc_host (
  // link
  input wire logic link_clk,
  input wire logic lk_busy,
  input wire logic lk_rvalid,
  input wire logic [7:0] lk_rdata,
  output sooc_pkg::sooc_cmd_s lk_cmd,
  output logic lk_cmd_valid
);
  import sooc_pkg::*;
  initial begin
    lk_cmd_valid = 1'b0;
    lk_cmd = '0;
  end
  // held across the taking edge; released lines show the inverse, not the last value
  task automatic xfer(input logic rd, input logic hd, input logic [7:0] code,
                      input logic [7:0] data, output logic [7:0] rdata, output logic ok);
    logic got;
    got = 1'b0;
    ok = 1'b0;
    rdata = 8'h00;
    @(negedge link_clk);
    // busy only moves on a rising edge, so a low level here holds at the taking edge
    for (int w = 0; w < 80 && lk_busy; w++) begin
      @(negedge link_clk);
    end
    lk_cmd_valid = 1'b1;
    lk_cmd = '{rd, hd, code, data};
    @(negedge link_clk);
    lk_cmd_valid = 1'b0;
    lk_cmd = ~lk_cmd;
    for (int n = 0; n < 80 && !ok; n++) begin
      @(negedge link_clk);
      if (lk_rvalid) begin
        got = 1'b1;
        rdata = lk_rdata;
      end
      ok = !lk_busy && (got || !rd);
    end
  endtask
  // clearing is always sent bare
  task automatic clr(output logic ok);
    logic [7:0] v;
    xfer(1'b0, 1'b0, 8'h03, 8'h00, v, ok);
  endtask
endmodule

// file: dv/tb.sv
// self-checking bench for the supply on/off command control
// assumes the host model drives the link; pins change at ref_clk falls
`timescale 1ns/100ps
module tb;
  import sooc_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_pin = 1'b0;
  logic bias_ok = 1'b1;
  logic pg_forced = 1'b0;
  logic [15:0] pgood_in = 16'h0000;
  logic [15:0] fault_now = 16'h0000;
  logic wdog_event = 1'b0;
  logic lk_cmd_valid, lk_busy, lk_rvalid, off_soft, margin_act_faults, margin_active, alert;
  logic ok;
  logic [7:0] lk_rdata, rd_v;
  logic [15:0] supply_enable_outputs;
  sooc_cmd_s lk_cmd;
  sooc_margin_e margin_sel;
  int failures = 0;
  int samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  // link clock offset so its edges drift against the core clock
  initial begin
    #2.3;
    forever #7.5 link_clk = ~link_clk;
  end
  sooc_host host (.link_clk(link_clk), .lk_busy(lk_busy), .lk_rvalid(lk_rvalid),
    .lk_rdata(lk_rdata), .lk_cmd(lk_cmd), .lk_cmd_valid(lk_cmd_valid));
  sooc_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(rst_n),
    .lk_cmd_valid(lk_cmd_valid), .lk_cmd(lk_cmd), .lk_busy(lk_busy), .lk_rvalid(lk_rvalid),
    .lk_rdata(lk_rdata), .ctrl_pin(ctrl_pin), .bias_ok(bias_ok), .pg_forced(pg_forced),
    .pgood_in(pgood_in), .fault_now(fault_now), .wdog_event(wdog_event),
    .supply_enable_outputs(supply_enable_outputs), .off_soft(off_soft),
    .margin_sel(margin_sel), .margin_act_faults(margin_act_faults),
    .margin_active(margin_active), .alert(alert));
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // pins act three core cycles late, margin status one more
  task automatic settle;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic done(input logic good);
    if (!good) begin
      failures++;
      $display("ERROR link handshake expected done seen stuck");
      end_of_test();
    end
    settle();
  endtask
  task automatic xf(input logic rd, input logic hd, input logic [7:0] code, input logic [7:0] d);
    host.xfer(rd, hd, code, d, rd_v, ok);
    done(ok);
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] d);
    xf(1'b0, 1'b1, code, d);
  endtask
  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    xf(1'b1, 1'b0, code, 8'h00);
    chk("read", exp, rd_v);
  endtask
  task automatic clr;
    host.clr(ok);
    done(ok);
  endtask
  task automatic pin(input logic v, input logic [15:0] en);
    ctrl_pin = v;
    settle();
    chk("enables", en, supply_enable_outputs);
  endtask
  task automatic t_reset;
    chk("enables", 16'hFFFF, supply_enable_outputs);
    rd(8'h02, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h80, 8'h01);
    pin(1'b1, 16'hFFFF);
    bias_ok = 1'b0;
    pin(1'b1, 16'h0000);
    chk("soft", 16'h0000, off_soft);
    $display("test reset done");
  endtask
  task automatic t_op;
    logic [15:0] tab [8];
    logic [15:0] e;
    tab = '{16'h80A0, 16'h4040, 16'h94A2, 16'h0000, 16'hA8A5, 16'h98A3, 16'hA4A4, 16'h0000};
    wr(8'h02, 8'h18);
    bias_ok = 1'b1;
    pin(1'b1, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      e = tab[i];
      wr(8'h01, e[15:8]);
      chk("enables", {16{e[7]}}, supply_enable_outputs);
      chk("soft", e[6], off_soft);
      if (e[5]) begin
        chk("margin", e[2:1], margin_sel);
        chk("act", e[0], margin_act_faults);
      end
    end
    wr(8'h02, 8'h10);
    wr(8'h01, 8'hA4);
    chk("margin", SOOC_MARG_HIGH, margin_sel);
    chk("enables", 16'h0000, supply_enable_outputs);
    $display("test operation done");
  endtask
  task automatic t_pin;
    wr(8'h02, 8'h1E);
    pin(1'b0, 16'h0000);
    wr(8'h01, 8'h80);
    chk("enables", 16'h0000, supply_enable_outputs);
    pin(1'b1, 16'hFFFF);
    wr(8'h01, 8'h40);
    chk("enables", 16'h0000, supply_enable_outputs);
    wr(8'h01, 8'h80);
    pin(1'b0, 16'h0000);
    chk("soft", 16'h0001, off_soft);
    wr(8'h02, 8'h15);
    chk("enables", 16'h0000, supply_enable_outputs);
    pin(1'b1, 16'h0000);
    pin(1'b0, 16'hFFFF);
    wr(8'h01, 8'h00);
    chk("enables", 16'hFFFF, supply_enable_outputs);
    pin(1'b1, 16'h0000);
    chk("soft", 16'h0000, off_soft);
    wr(8'h02, 8'h18);
    pin(1'b0, 16'h0000);
    $display("test pin done");
  endtask
  task automatic t_margin;
    wr(8'h01, 8'h94);
    chk("active", 16'h0000, margin_active);
    pgood_in = 16'h7FFF;
    settle();
    chk("active", 16'h0000, margin_active);
    pgood_in = 16'hFFFF;
    settle();
    chk("active", 16'h0001, margin_active);
    pgood_in = 16'h0000;
    pg_forced = 1'b1;
    settle();
    chk("active", 16'h0001, margin_active);
    wr(8'h01, 8'h00);
    chk("active", 16'h0000, margin_active);
    pg_forced = 1'b0;
    $display("test margin done");
  endtask
  task automatic t_fault;
    wr(8'h01, 8'h80);
    fault_now = 16'h0001;
    settle();
    chk("alert", 16'h0001, alert);
    clr();
    chk("alert", 16'h0000, alert);
    rd(8'h81, 8'h01);
    rd(8'h80, 8'h00);
    chk("enables", 16'hFFFF, supply_enable_outputs);
    fault_now = 16'h0003;
    settle();
    chk("alert", 16'h0001, alert);
    clr();
    wr(8'h01, 8'h55);
    chk("alert", 16'h0001, alert);
    rd(8'h80, 8'h04);
    chk("enables", 16'hFFFF, supply_enable_outputs);
    clr();
    @(negedge ref_clk);
    wdog_event = 1'b1;
    @(negedge ref_clk);
    wdog_event = 1'b0;
    rd(8'h80, 8'h02);
    clr();
    xf(1'b0, 1'b1, 8'h03, 8'h00);
    chk("alert", 16'h0001, alert);
    rd(8'h80, 8'h04);
    fault_now = 16'h0000;
    clr();
    $display("test fault done");
  endtask
  task automatic t_wp;
    wr(8'h01, 8'h00);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h1F);
    wr(8'h02, 8'h18);
    wr(8'h10, 8'h80);
    wr(8'h02, 8'h10);
    rd(8'h02, 8'h18);
    wr(8'h01, 8'h80);
    chk("enables", 16'h0000, supply_enable_outputs);
    rd(8'h10, 8'h80);
    wr(8'h10, 8'h40);
    wr(8'h01, 8'h80);
    chk("enables", 16'hFFFF, supply_enable_outputs);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h10);
    rd(8'h02, 8'h18);
    wr(8'h10, 8'h20);
    wr(8'h02, 8'h10);
    rd(8'h02, 8'h10);
    wr(8'h10, 8'h00);
    chk("alert", 16'h0000, alert);
    rd(8'h55, 8'h00);
    chk("alert", 16'h0001, alert);
    $display("test protect done");
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    settle();
    t_reset();
    t_op();
    t_pin();
    t_margin();
    t_fault();
    t_wp();
    end_of_test();
  end
endmodule
